// [src/icc_pkg.sv]
// Shared constants and types of the impedance calibration controller.
// Assumes a single 125 MHz clock and a plain register port on the same clock.
package icc_pkg;

   // Bank count and width of the resistor segment code.
   localparam int          ICC_NB       = 4;
   localparam int          ICC_CW       = 6;
   localparam logic [5:0]  ICC_CODE_RST = 6'h20;
   localparam logic [5:0]  ICC_CODE_MAX = 6'h3f;

   // Clock rate and the timing of the engine.
   localparam int          ICC_CLK_MHZ   = 125;
   localparam int          ICC_STEP_NS   = 64;
   localparam int          ICC_STEP_CYC  = (ICC_STEP_NS * ICC_CLK_MHZ + 999) / 1000;
   localparam int          ICC_TRACK_US  = 20;
   localparam int          ICC_TRACK_CYC = ICC_TRACK_US * ICC_CLK_MHZ;

   // Register offsets, byte addresses on the register port.
   localparam logic [7:0]  ICC_OFS_CTRL     = 8'h00;
   localparam logic [7:0]  ICC_OFS_BANK_USE = 8'h04;
   localparam logic [7:0]  ICC_OFS_RESTRICT = 8'h08;
   localparam logic [7:0]  ICC_OFS_CASCADE  = 8'h0c;
   localparam logic [7:0]  ICC_OFS_MASTER   = 8'h10;
   localparam logic [7:0]  ICC_OFS_STATUS   = 8'h14;
   localparam logic [7:0]  ICC_OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0]  ICC_OFS_IRQ_MASK = 8'h1c;
   localparam logic [7:0]  ICC_OFS_CODE0    = 8'h20;

   // Control field positions and reset values.
   localparam int          ICC_CTRL_ONESHOT = 0;
   localparam int          ICC_CTRL_WAITM   = 1;
   localparam int          ICC_CTRL_DHOLD   = 2;
   localparam logic [2:0]  ICC_CTRL_RST     = 3'h4;
   localparam logic [3:0]  ICC_BANK_RST     = 4'h0;
   localparam logic [1:0]  ICC_MASTER_RST   = 2'h0;
   localparam logic [2:0]  ICC_IRQ_RST      = 3'h0;
   localparam logic [7:0]  ICC_LFSR_SEED    = 8'h5a;

   // Interrupt bit positions.
   localparam int          ICC_IRQ_MATCH = 0;
   localparam int          ICC_IRQ_LOCK  = 1;
   localparam int          ICC_IRQ_LOST  = 2;

   // Engine states.
   typedef enum logic [2:0] {
      ICC_ST_CAL,
      ICC_ST_TRACK,
      ICC_ST_QUIET,
      ICC_ST_HOLD
   } icc_state_type;

   // Configuration options written by software.
   typedef struct packed {
      logic done_hold;
      logic wait_match;
      logic oneshot;
   } icc_cfg_type;

   // Bank masks written by software.
   typedef struct packed {
      logic [ICC_NB-1:0] use_cal;
      logic [ICC_NB-1:0] restricted;
      logic [ICC_NB-1:0] cascaded;
      logic [1:0]        master;
   } icc_banks_type;

endpackage : icc_pkg

// [src/icc_sync2.sv]
// Two flip-flop synchroniser for a group of level inputs.
// Assumes the inputs are levels from outside the clk domain.
`timescale 1ns/100ps
module icc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : icc_sync2

// [src/icc_bank_cal.sv]
// Successive step search of one bank's resistor segment code.
// Assumes a synchronised comparator level and a one-cycle step enable.
`timescale 1ns/100ps
module icc_bank_cal
   import icc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              restart,
   input  wire logic              step,
   input  wire logic              cmp_hi,
   output logic      [ICC_CW-1:0] code,
   output logic                   matched
);

   logic have_dir_r;
   logic last_up_r;

   // A high comparator asks for more segments; saturate at both ends.
   wire can_up   = cmp_hi && (code != ICC_CODE_MAX);
   wire can_dn   = !cmp_hi && (code != '0);
   wire reversal = have_dir_r && (cmp_hi != last_up_r);

   // Match is declared when the search direction first reverses.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         code       <= ICC_CODE_RST;
         matched    <= 1'b0;
         have_dir_r <= 1'b0;
         last_up_r  <= 1'b0;
      end else if (restart) begin
         code       <= ICC_CODE_RST;
         matched    <= 1'b0;
         have_dir_r <= 1'b0;
      end else if (step) begin
         if (can_up) code <= code + 6'h01;
         if (can_dn) code <= code - 6'h01;
         have_dir_r <= 1'b1;
         last_up_r  <= cmp_hi;
         if (reversal) matched <= 1'b1;
      end
   end

endmodule : icc_bank_cal

// [src/icc_ctrl.sv]
// Impedance calibration controller: engine sequencing, start-up gating,
// recalibration handling, per-bank code distribution and register port.
// Assumes comparator levels arrive from the analog side asynchronously,
// and that recal_req, cfg_end and the register port share clk.
//
// Operation
// - Engine switches resistor segments per bank to match the reference.
// - Calibration starts by itself after reset, with no user request.
// - By default configuration-complete stays low until the first match.
// - A recalibration request resets the engine and restarts calibration.
// - Calibrated I/Os count as unavailable until the lock flag is high.
// - With wait-for-match set, start-up holds until the first match.
// - Continuous tracking calibrates once, then keeps updating codes.
// - One-shot policy calibrates at start and on each request only.
// - Restricted banks skip the initial calibration.
// - Tracking without request updates restricted banks after random delay.
// - One-shot without request never updates restricted banks.
// - Each bank uses its reference pin; unused, the pin is ordinary I/O.
// - Banks of a column may share one reference node.
// - Cascaded banks take their code from the master bank.
`timescale 1ns/100ps
module icc_ctrl
   import icc_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   input  wire logic                         cfg_end,
   input  wire logic                         recal_req,
   input  wire logic [ICC_NB-1:0]            cmp_hi_pin,
   input  wire logic [7:0]                   reg_addr,
   input  wire logic [31:0]                  reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [31:0]                  reg_rdata,
   output logic                              cfg_done,
   output logic                              startup_hold,
   output logic                              calib_lock_flag,
   output logic      [ICC_NB-1:0][ICC_CW-1:0] seg_code,
   output logic      [ICC_NB-1:0]            seg_valid,
   output logic      [ICC_NB-1:0]            ref_pin_is_io,
   output logic                              irq
);

   // Software state.
   icc_cfg_type        cfg_r;
   icc_banks_type      banks_r;
   logic [2:0]         irq_stat_r;
   logic [2:0]         irq_mask_r;

   // Engine state.
   icc_state_type      state_r;
   icc_state_type      state_nxt;
   logic               first_match_r;
   logic               lock_r;
   logic               recal_seen_r;
   logic               late_ok_r;
   logic               cfg_end_r;
   logic [7:0]         lfsr_r;
   logic [3:0]         step_cnt_r;
   logic [11:0]        track_cnt_r;

   // Per-bank search results.
   logic [ICC_NB-1:0]              cmp_hi;
   logic [ICC_NB-1:0][ICC_CW-1:0]  raw_code;
   logic [ICC_NB-1:0]              matched;

   // Comparator levels come from the analog side and are synchronised.
   icc_sync2 #(
      .W        (ICC_NB)
   ) u_cmp_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (cmp_hi_pin),
      .sync_out (cmp_hi)
   );

   // Step divider: one-cycle pulse every ICC_STEP_CYC cycles.
   wire step_tick  = (step_cnt_r == 4'(ICC_STEP_CYC - 1));
   // Tracking interval: one-cycle pulse every ICC_TRACK_CYC cycles.
   wire track_tick = (track_cnt_r == 12'(ICC_TRACK_CYC - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         step_cnt_r  <= '0;
         track_cnt_r <= '0;
      end else begin
         step_cnt_r  <= step_tick ? 4'h0 : step_cnt_r + 4'h1;
         track_cnt_r <= track_tick ? 12'h000 : track_cnt_r + 12'h001;
      end
   end

   // Engine decode.
   wire in_hold   = (state_r == ICC_ST_HOLD);
   wire in_cal    = (state_r == ICC_ST_CAL);
   wire in_track  = (state_r == ICC_ST_TRACK);
   wire searching = in_cal || in_track;
   // Banks that run their own search: in use and not fed by cascade.
   wire [ICC_NB-1:0] own_search = banks_r.use_cal & ~banks_r.cascaded;
   wire all_match = &(matched | ~own_search);
   wire cal_done  = in_cal && all_match;
   // The search restarts on entry to hold and on each tracking update.
   wire bank_restart = recal_req || in_hold || (in_track && track_tick && all_match);

   // One search engine per bank.
   genvar gi;
   generate
      for (gi = 0; gi < ICC_NB; gi++) begin : g_bank
         icc_bank_cal u_cal (
            .clk     (clk),
            .sys_rst (sys_rst),
            .restart (bank_restart),
            .step    (step_tick && searching && own_search[gi]),
            .cmp_hi  (cmp_hi[gi]),
            .code    (raw_code[gi]),
            .matched (matched[gi])
         );
      end
   endgenerate

   // Next state: start automatically, hold while a request stands.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ICC_ST_CAL: begin
            if (all_match) begin
               state_nxt = cfg_r.oneshot ? ICC_ST_QUIET : ICC_ST_TRACK;
            end
         end
         // A later switch to one-shot stops background tracking at once.
         ICC_ST_TRACK: state_nxt = cfg_r.oneshot ? ICC_ST_QUIET : ICC_ST_TRACK;
         ICC_ST_QUIET: state_nxt = ICC_ST_QUIET;
         ICC_ST_HOLD:  state_nxt = recal_req ? ICC_ST_HOLD : ICC_ST_CAL;
      endcase
      if (recal_req) state_nxt = ICC_ST_HOLD;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ICC_ST_CAL;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Lock falls during a request and rises on the restarted first match.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lock_r <= 1'b0;
      end else if (recal_req) begin
         lock_r <= 1'b0;
      end else if (cal_done) begin
         lock_r <= 1'b1;
      end
   end

   // First match since reset, kept across later requests.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         first_match_r <= 1'b0;
      end else if (cal_done) begin
         first_match_r <= 1'b1;
      end
   end

   // A completed request lets restricted banks take codes from then on.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         recal_seen_r <= 1'b0;
      end else if (in_hold && !recal_req) begin
         recal_seen_r <= 1'b1;
      end
   end

   // End of configuration is a level from the configuration logic.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_end_r <= 1'b0;
      end else if (cfg_end) begin
         cfg_end_r <= 1'b1;
      end
   end

   // Free-running pseudo random source for the late restricted update.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lfsr_r <= ICC_LFSR_SEED;
      end else begin
         lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      end
   end

   // Under tracking, restricted banks join at an unpredictable update.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         late_ok_r <= 1'b0;
      end else if (in_track && track_tick && cfg_end_r && lfsr_r[0]) begin
         late_ok_r <= 1'b1;
      end
   end

   // Codes are published at the first match, and under tracking at
   // every interval; one-shot publishes nothing between requests.
   wire publish = cal_done || (in_track && track_tick && all_match);
   // Restricted banks are skipped in the initial calibration.
   wire restrict_ok = recal_seen_r || late_ok_r;
   wire [ICC_CW-1:0] master_code = raw_code[banks_r.master];

   // Applied segment codes, one register per bank.
   generate
      for (gi = 0; gi < ICC_NB; gi++) begin : g_apply
         wire take = banks_r.use_cal[gi] && (!banks_r.restricted[gi] || restrict_ok);
         // Cascaded banks copy the master bank's search.
         wire [ICC_CW-1:0] src = banks_r.cascaded[gi] ? master_code : raw_code[gi];
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               seg_code[gi]  <= ICC_CODE_RST;
               seg_valid[gi] <= 1'b0;
            end else if (!banks_r.use_cal[gi]) begin
               seg_valid[gi] <= 1'b0;
            end else if (publish && take) begin
               seg_code[gi]  <= src;
               seg_valid[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // Reference pin is ordinary I/O when the bank uses no calibration.
   assign ref_pin_is_io = ~banks_r.use_cal;

   // Start-up gating outputs.
   assign cfg_done        = cfg_end_r && (!cfg_r.done_hold || first_match_r);
   assign startup_hold    = cfg_end_r && cfg_r.wait_match && !first_match_r;
   assign calib_lock_flag = lock_r;

   // Register port decode.
   wire wr_ctrl   = reg_wr && (reg_addr == ICC_OFS_CTRL);
   wire wr_use    = reg_wr && (reg_addr == ICC_OFS_BANK_USE);
   wire wr_rstr   = reg_wr && (reg_addr == ICC_OFS_RESTRICT);
   wire wr_casc   = reg_wr && (reg_addr == ICC_OFS_CASCADE);
   wire wr_master = reg_wr && (reg_addr == ICC_OFS_MASTER);
   wire wr_mask   = reg_wr && (reg_addr == ICC_OFS_IRQ_MASK);
   wire rd_stat   = reg_rd && (reg_addr == ICC_OFS_IRQ_STAT);
   wire code_hit  = (reg_addr[7:4] == ICC_OFS_CODE0[7:4])
                    && ({1'b0, reg_addr[3:0]} < 5'(ICC_NB * 4))
                    && (reg_addr[1:0] == 2'h0);
   wire [1:0] code_idx = reg_addr[3:2];

   // Configuration registers.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_r   <= ICC_CTRL_RST;
         banks_r <= {ICC_BANK_RST, ICC_BANK_RST, ICC_BANK_RST, ICC_MASTER_RST};
      end else begin
         if (wr_ctrl)   cfg_r            <= reg_wdata[2:0];
         if (wr_use)    banks_r.use_cal    <= reg_wdata[ICC_NB-1:0];
         if (wr_rstr)   banks_r.restricted <= reg_wdata[ICC_NB-1:0];
         if (wr_casc)   banks_r.cascaded   <= reg_wdata[ICC_NB-1:0];
         if (wr_master) banks_r.master     <= reg_wdata[1:0];
      end
   end

   // Interrupt events.
   wire [2:0] irq_evt = {lock_r && recal_req, cal_done, cal_done && !first_match_r};

   // Sticky status cleared by its read; a new event wins over the clear.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat_r <= ICC_IRQ_RST;
         irq_mask_r <= ICC_IRQ_RST;
      end else begin
         irq_stat_r <= (rd_stat ? 3'h0 : irq_stat_r) | irq_evt;
         if (wr_mask) irq_mask_r <= reg_wdata[2:0];
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   // Read multiplexer; unmapped offsets read zero.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (reg_addr)
         ICC_OFS_CTRL:     rd_mux[2:0] = cfg_r;
         ICC_OFS_BANK_USE: rd_mux[ICC_NB-1:0] = banks_r.use_cal;
         ICC_OFS_RESTRICT: rd_mux[ICC_NB-1:0] = banks_r.restricted;
         ICC_OFS_CASCADE:  rd_mux[ICC_NB-1:0] = banks_r.cascaded;
         ICC_OFS_MASTER:   rd_mux[1:0] = banks_r.master;
         ICC_OFS_STATUS:   rd_mux[10:0] = {matched, state_r, late_ok_r, recal_seen_r,
                                           first_match_r, lock_r};
         ICC_OFS_IRQ_STAT: rd_mux[2:0] = irq_stat_r;
         ICC_OFS_IRQ_MASK: rd_mux[2:0] = irq_mask_r;
         default: begin
            if (code_hit) rd_mux[ICC_CW-1:0] = seg_code[code_idx];
         end
      endcase
   end

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

endmodule : icc_ctrl

// [tb/icc_ctrl_sva.sv]
// Concurrent checks on the ports of the calibration controller.
// Assumes binding to icc_ctrl, with every port named as in the design.
`timescale 1ns/100ps
module icc_ctrl_sva
   import icc_pkg::*;
(
   input wire logic                          clk,
   input wire logic                          sys_rst,
   input wire logic                          recal_req,
   input wire logic [7:0]                    reg_addr,
   input wire logic [31:0]                   reg_wdata,
   input wire logic                          reg_wr,
   input wire logic                          reg_rd,
   input wire logic [31:0]                   reg_rdata,
   input wire logic                          cfg_done,
   input wire logic                          startup_hold,
   input wire logic                          calib_lock_flag,
   input wire logic [ICC_NB-1:0][ICC_CW-1:0] seg_code,
   input wire logic [ICC_NB-1:0]             ref_pin_is_io,
   input wire logic                          irq
);
   logic [2:0] ctrl_r;
   logic [3:0] use_r;
   logic [2:0] mask_r;
   logic       seen_r;

   // Shadows of the written options and a sticky flag for the first lock.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= ICC_CTRL_RST;
         use_r  <= ICC_BANK_RST;
         mask_r <= ICC_IRQ_RST;
         seen_r <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == ICC_OFS_CTRL) ctrl_r <= reg_wdata[2:0];
         if (reg_wr && reg_addr == ICC_OFS_BANK_USE) use_r <= reg_wdata[3:0];
         if (reg_wr && reg_addr == ICC_OFS_IRQ_MASK) mask_r <= reg_wdata[2:0];
         if (calib_lock_flag) seen_r <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Port, lock and code relations.
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_lock_drop: assert property (recal_req |=> !calib_lock_flag)
      else $error("lock high while a request is active");
   a_lock_back: assert property ($fell(recal_req) |-> ##[1:1000] calib_lock_flag)
      else $error("lock did not return after a request");
   a_done_first: assert property (cfg_done && ctrl_r[ICC_CTRL_DHOLD] |-> seen_r || calib_lock_flag)
      else $error("configuration done before the first match");
   a_hold_first: assert property (startup_hold |-> ctrl_r[ICC_CTRL_WAITM] && !seen_r)
      else $error("start-up held without cause");
   a_irq_masked: assert property (mask_r == 3'h0 |-> !irq)
      else $error("interrupt high while fully masked");
   a_ref_io: assert property (ref_pin_is_io == ~use_r)
      else $error("reference pin use does not follow bank use");
   a_code_lock: assert property (!$stable(seg_code) |-> calib_lock_flag)
      else $error("segment code changed while unlocked");
   a_quiet_code: assert property (ctrl_r[ICC_CTRL_ONESHOT] && !$stable(seg_code) |-> $rose(calib_lock_flag))
      else $error("one-shot code changed without a new match");

   c_recal: cover property (recal_req ##1 !calib_lock_flag);
   c_relock: cover property ($rose(calib_lock_flag));
   c_irq: cover property (irq);
endmodule : icc_ctrl_sva

// [tb/icc_fabric_model.sv]
// Fabric-side partner: recalibration requests and reference comparators.
// Assumes the bench commands each request with a one-cycle go pulse.
`timescale 1ns/100ps
module icc_fabric_model
   import icc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              recal_go,
   input  wire logic [7:0]        recal_len,
   output logic                   recal_req,
   output logic      [ICC_NB-1:0] cmp_hi_pin
);
   logic [7:0] left_r;

   // Holds the request for recal_len cycles; a long hold acts as a slow user.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         recal_req <= 1'b0;
         left_r    <= 8'h0;
      end else if (recal_go) begin
         recal_req <= 1'b1;
         left_r    <= recal_len;
      end else if (left_r > 8'h1) begin
         left_r <= left_r - 8'h1;
      end else begin
         recal_req <= 1'b0;
         left_r    <= 8'h0;
      end
   end

   // Noisy comparators, so that every search meets a reversal within a few steps.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) cmp_hi_pin <= '0;
      else cmp_hi_pin <= ICC_NB'($urandom);
   end
endmodule : icc_fabric_model

// [tb/tb.sv]
// Self-checking bench of the calibration controller with its fabric partner.
// Assumes the package constants and one 125 MHz clock.
`timescale 1ns/100ps
module tb
   import icc_pkg::*;
;
   logic                          clk, sys_rst, cfg_end, recal_req, reg_wr, reg_rd;
   logic                          recal_go, cfg_done, startup_hold, calib_lock_flag, irq, rd_q;
   logic [7:0]                    reg_addr, recal_len;
   logic [31:0]                   reg_wdata, reg_rdata;
   logic [ICC_NB-1:0]             cmp_hi_pin, seg_valid, ref_pin_is_io, v;
   logic [ICC_NB-1:0][ICC_CW-1:0] seg_code, code_q;
   logic [63:0]                   rq[$];
   int                            fail_count, total_checks, moves, seed;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   icc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .cfg_end(cfg_end), .recal_req(recal_req),
      .cmp_hi_pin(cmp_hi_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_done(cfg_done), .startup_hold(startup_hold),
      .calib_lock_flag(calib_lock_flag), .seg_code(seg_code), .seg_valid(seg_valid),
      .ref_pin_is_io(ref_pin_is_io), .irq(irq));

   icc_fabric_model fab (.clk(clk), .sys_rst(sys_rst), .recal_go(recal_go),
      .recal_len(recal_len), .recal_req(recal_req), .cmp_hi_pin(cmp_hi_pin));

   task automatic chk_port(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_port

   task automatic chk_reg(input logic [63:0] me, input logic [31:0] got);
      total_checks++;
      if ((got & me[63:32]) !== me[31:0]) begin
         fail_count++;
         $display("unexpected reg_rdata expected %h seen %h", me[31:0], got);
      end
   endtask : chk_reg

   // Register port master: one-cycle strobes launched after a clock edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      rq.push_back({m, e & m});
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   // Read answers stand only in the cycle after the strobe, so they are taken there.
   always @(posedge clk) begin
      if (rd_q) chk_reg(rq.pop_front(), reg_rdata);
      rd_q <= reg_rd;
   end

   task automatic wait_lock(input string nm);
      int n;
      n = 0;
      while (calib_lock_flag !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk_port(nm, 32'h1, {31'h0, calib_lock_flag});
   endtask : wait_lock

   // Asks the partner for one request, then sees lock fall and come back.
   task automatic recal(input logic [7:0] len);
      @(posedge clk);
      recal_len <= len;
      recal_go  <= 1'b1;
      @(posedge clk);
      recal_go <= 1'b0;
      repeat (3) @(posedge clk);
      chk_port("lock_drop", 32'h0, {31'h0, calib_lock_flag});
      wait_lock("lock_back");
   endtask : recal

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      close_out();
   end

   // Main sequence: defaults, bank use, tracking recalibration, one-shot policy.
   initial begin
      seed = $urandom(63343);
      sys_rst = 1'b1;
      {cfg_end, recal_go, reg_wr, reg_rd, rd_q} = 5'h0;
      {reg_addr, recal_len, reg_wdata} = 48'h0;
      fail_count = 0;
      total_checks = 0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      wait_lock("lock_start");
      chk_port("ref_io", 32'hf, {28'h0, ref_pin_is_io});
      chk_port("cfg_done", 32'h0, {31'h0, cfg_done});
      rd(ICC_OFS_CTRL, {29'h0, ICC_CTRL_RST}, 32'hffffffff);
      rd(ICC_OFS_BANK_USE, 32'h0, 32'hffffffff);
      rd(ICC_OFS_RESTRICT, 32'h0, 32'hffffffff);
      rd(ICC_OFS_MASTER, 32'h0, 32'hffffffff);
      rd(ICC_OFS_IRQ_MASK, 32'h0, 32'hffffffff);
      rd(8'hfc, 32'h0, 32'hffffffff);
      cfg_end <= 1'b1;
      repeat (3) @(posedge clk);
      chk_port("cfg_done", 32'h1, {31'h0, cfg_done});
      rd(ICC_OFS_IRQ_STAT, 32'h3, 32'h7);
      $display("test defaults done");
      for (int i = 0; i < 4; i++) begin
         v = ICC_NB'($urandom);
         wr(ICC_OFS_BANK_USE, {28'h0, v});
         @(posedge clk);
         chk_port("ref_io", {28'h0, ~v}, {28'h0, ref_pin_is_io});
      end
      $display("test bank_use done");
      // The default tracking policy stays in force here.
      wr(ICC_OFS_BANK_USE, 32'hf);
      wr(ICC_OFS_IRQ_MASK, 32'h0);
      recal(8'(1 + $urandom_range(7)));
      chk_port("seg_valid", 32'hf, {28'h0, seg_valid});
      chk_port("irq", 32'h0, {31'h0, irq});
      wr(ICC_OFS_IRQ_MASK, 32'h7);
      @(posedge clk);
      chk_port("irq", 32'h1, {31'h0, irq});
      rd(ICC_OFS_IRQ_STAT, 32'h6, 32'h6);
      repeat (2) @(posedge clk);
      chk_port("irq", 32'h0, {31'h0, irq});
      code_q = seg_code;
      moves = 0;
      repeat (3 * ICC_TRACK_CYC) begin
         @(posedge clk);
         if (seg_code !== code_q) moves++;
         code_q = seg_code;
      end
      chk_port("track_moves", 32'h1, {31'h0, moves > 0});
      $display("test tracking done");
      sys_rst <= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      wr(ICC_OFS_CTRL, 32'h5);
      wr(ICC_OFS_BANK_USE, 32'hf);
      wr(ICC_OFS_RESTRICT, 32'h1);
      wr(ICC_OFS_CASCADE, 32'h2);
      repeat (2 * ICC_TRACK_CYC) @(posedge clk);
      chk_port("restricted_valid", 32'h0, {31'h0, seg_valid[0]});
      recal(8'd40);
      chk_port("restricted_valid", 32'h1, {31'h0, seg_valid[0]});
      chk_port("cascade_code", {26'h0, seg_code[0]}, {26'h0, seg_code[1]});
      code_q = seg_code;
      repeat (2 * ICC_TRACK_CYC) @(posedge clk);
      chk_port("quiet_code", {8'h0, code_q}, {8'h0, seg_code});
      rd(ICC_OFS_CODE0, {26'h0, code_q[0]}, 32'hffffffff);
      $display("test one_shot done");
      close_out();
   end
endmodule : tb

bind icc_ctrl icc_ctrl_sva u_sva (.clk(clk), .sys_rst(sys_rst), .recal_req(recal_req),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .cfg_done(cfg_done), .startup_hold(startup_hold),
   .calib_lock_flag(calib_lock_flag), .seg_code(seg_code), .ref_pin_is_io(ref_pin_is_io),
   .irq(irq));
